// File: logic/cbi_cpu.sv
// Behaviour
// [R01] Bus cycle lasts at least four phases
// [R02] Address phase one, turnaround two, data after
// [R03] Not ready inserts wait phases before four
// [R04] Idle phases when no transfer needed
// [R05] Latch strobe in phase one, falling capture
// [R06] Cycle-type status codes zero through seven
// [R07] Upper status phases two-four, enable flag
// [R08] Segment status reports segment of cycle
// [R09] I/O space: top address lines low
// [R10] Reset held high over four clocks
// [R11] Reset aborts; ten clocks then FFFF0H
// [R12] Vector table entries four bytes each
// [R13] Non-maskable beats maskable request
// [R14] Non-maskable pulse lasts two clocks minimum
// [R15] Interrupts taken only at instruction boundaries; code also takes them in halt without one
// [R16] Maskable request held until acknowledged
// [R17] Taking interrupt clears enable, pushes flags
// [R18] Lock from phase two to phase two
// [R19] Second acknowledge supplies type, times four
// [R20] Interrupt return restores enable flag
// [R21] Halt left only by interrupt or reset
// [R22] Strobes active phase two until four
// [R23] Ready sampled end of three and waits
// [R24] Config select picks own or external strobes
module cbi_cpu
  import cbi_pkg::*;
#(
  parameter logic [7:0] NMI_TYPE = 8'h02
)
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Bus
  cbi_bus_if.cpu           bus,
  // Transfer requests
  input  wire logic        req_valid_in,
  input  wire logic [2:0]  req_kind_in,
  input  wire logic [19:0] req_addr_in,
  input  wire logic [1:0]  req_seg_in,
  input  wire logic [7:0]  req_wdata_in,
  output logic             req_ready_out,
  output logic             rsp_valid_out,
  output logic [7:0]       rsp_data_out,
  // Instruction flow
  input  wire logic        boundary_in,
  input  wire logic        halt_in,
  input  wire logic        if_set_in,
  input  wire logic        if_clr_in,
  input  wire logic        interrupt_return_in,
  input  wire logic        interrupt_return_if_in,
  output logic             int_taken_out,
  output logic [19:0]      int_addr_out,
  output logic             flags_push_out,
  output logic             if_flag_out,
  output logic             halted_out
);
  cbi_phase_t  ph_q;
  cbi_phase_t  ph_d;
  logic [2:0]  kind_q;
  logic [2:0]  kind_d;
  logic [19:0] addr_q;
  logic [19:0] addr_d;
  logic [1:0]  seg_q;
  logic [1:0]  seg_d;
  logic [7:0]  wdata_q;
  logic [7:0]  wdata_d;
  logic [1:0]  ack_q;
  logic [1:0]  ack_d;
  logic [3:0]  seq_cnt_q;
  logic [7:0]  vec_q;
  logic        nmi_prev_q;
  logic        nmi_pend_q;
  logic        bnd_q;
  logic        take_nmi;
  logic        take_irq;
  logic        req_take;
  logic        int_req;
  logic        at_bnd;
  logic        data_edge;
  logic        min_mode;
  logic        in_cycle;
  logic        strobe_win;

  // [R13] NMI first
  assign int_req   = nmi_pend_q || (bus.mask_irq && if_flag_out);
  assign req_take  = ph_q == PH_IDLE && ack_q == ACK_NONE &&
                     req_valid_in && req_ready_out;
  assign at_bnd    = bnd_q || boundary_in;
  // [R23] Ready sample point
  assign data_edge = (ph_q == PHASE_THREE || ph_q == WAIT_PHASE) &&
                     bus.ready;
  assign min_mode  = bus.config_select;

  always_comb
  begin
    ph_d     = ph_q;
    kind_d   = kind_q;
    addr_d   = addr_q;
    seg_d    = seg_q;
    wdata_d  = wdata_q;
    ack_d    = ack_q;
    take_nmi = 1'b0;
    take_irq = 1'b0;
    case (ph_q)
      PH_RST_HOLD:
        ph_d = PH_RST_SEQ;
      PH_RST_SEQ:
        // [R11] Boot fetch
        if (seq_cnt_q == RESET_SEQ_LAST)
        begin
          ph_d   = PHASE_ONE;
          kind_d = CT_FETCH;
          addr_d = RESET_VECTOR;
          seg_d  = SEG_CODE;
        end
      PH_IDLE, PH_HALT:
        if (ack_q == ACK_FIRST)
        begin
          ph_d   = PHASE_ONE;
          ack_d  = ACK_SECOND;
        end
        else if (req_take)
        begin
          ph_d    = PHASE_ONE;
          kind_d  = req_kind_in;
          // [R09] I/O address format
          addr_d  = cbi_io_addr(req_addr_in, req_kind_in);
          seg_d   = req_seg_in;
          wdata_d = req_wdata_in;
        end
        // [R15] Boundary or halt
        else if (int_req && (ph_q == PH_HALT || at_bnd))
        begin
          ph_d = PH_IDLE;
          if (nmi_pend_q)
            take_nmi = 1'b1;
          else
          begin
            take_irq = 1'b1;
            ph_d     = PHASE_ONE;
            kind_d   = CT_INT_ACK_STROBE_N;
            addr_d   = 20'h00000;
            seg_d    = SEG_CODE;
            ack_d    = ACK_FIRST;
          end
        end
        // [R21] Enter halt
        else if (ph_q == PH_IDLE && halt_in)
          ph_d = PH_HALT;
      // [R01] Four phases in order
      PHASE_ONE:
        ph_d = PHASE_TWO;
      PHASE_TWO:
        ph_d = PHASE_THREE;
      PHASE_THREE, WAIT_PHASE:
        // [R03] Wait until ready
        ph_d = bus.ready ? PHASE_FOUR : WAIT_PHASE;
      PHASE_FOUR:
      begin
        // [R04] Idle between cycles
        ph_d = PH_IDLE;
        if (ack_q == ACK_SECOND)
          ack_d = ACK_NONE;
      end
      default:
        ph_d = PH_RST_HOLD;
    endcase
    // [R11] Reset aborts at once
    if (bus.reset)
    begin
      ph_d  = PH_RST_HOLD;
      ack_d = ACK_NONE;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ph_q    <= PH_RST_HOLD;
      kind_q  <= CT_PASSIVE;
      addr_q  <= 20'h00000;
      seg_q   <= SEG_CODE;
      wdata_q <= 8'h00;
      ack_q   <= ACK_NONE;
    end
    else
    begin
      ph_q    <= ph_d;
      kind_q  <= kind_d;
      addr_q  <= addr_d;
      seg_q   <= seg_d;
      wdata_q <= wdata_d;
      ack_q   <= ack_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      seq_cnt_q <= 4'h0;
    else if (ph_q == PH_RST_SEQ && !bus.reset)
      seq_cnt_q <= seq_cnt_q + 4'h1;
    else
      seq_cnt_q <= 4'h0;
  end

  // Interrupt bookkeeping; set wins over clear
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      bnd_q      <= 1'b0;
    end
    else
    begin
      nmi_prev_q <= bus.nmi;
      if (bus.nmi && !nmi_prev_q)
        nmi_pend_q <= 1'b1;
      else if (take_nmi || bus.reset)
        nmi_pend_q <= 1'b0;
      bnd_q <= at_bnd && !(ph_q == PH_IDLE && ack_q == ACK_NONE &&
                          !req_take);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      if_flag_out <= 1'b0;
    else if (bus.reset)
      if_flag_out <= 1'b0;
    // [R17] Clear enable on take
    else if (take_nmi || take_irq)
      if_flag_out <= 1'b0;
    // [R20] Return restores flag
    else if (interrupt_return_in)
      if_flag_out <= interrupt_return_if_in;
    else if (if_set_in)
      if_flag_out <= 1'b1;
    else if (if_clr_in)
      if_flag_out <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flags_push_out <= 1'b0;
      int_taken_out  <= 1'b0;
      int_addr_out   <= 20'h00000;
      vec_q          <= 8'h00;
    end
    else
    begin
      // [R17] Push flags
      flags_push_out <= take_nmi || take_irq;
      int_taken_out  <= 1'b0;
      // [R19] Type byte on second ack
      if (data_edge && ack_q == ACK_SECOND)
        vec_q <= bus.ad;
      // [R12] Four-byte table entry
      if (take_nmi)
      begin
        int_taken_out <= 1'b1;
        int_addr_out  <= cbi_ivt_addr(NMI_TYPE);
      end
      else if (ph_q == PHASE_FOUR && ack_q == ACK_SECOND && !bus.reset)
      begin
        int_taken_out <= 1'b1;
        int_addr_out  <= cbi_ivt_addr(vec_q);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= 8'h00;
      req_ready_out <= 1'b0;
      halted_out    <= 1'b0;
    end
    else
    begin
      rsp_valid_out <= 1'b0;
      if (data_edge && kind_q != CT_INT_ACK_STROBE_N && cbi_is_read(kind_q) &&
          !bus.reset)
      begin
        rsp_valid_out <= 1'b1;
        rsp_data_out  <= bus.ad;
      end
      req_ready_out <= ph_d == PH_IDLE && ack_d == ACK_NONE;
      halted_out    <= ph_d == PH_HALT;
    end
  end

  assign in_cycle   = ph_d == PHASE_ONE || ph_d == PHASE_TWO ||
                      ph_d == PHASE_THREE || ph_d == WAIT_PHASE ||
                      ph_d == PHASE_FOUR;
  assign strobe_win = ph_d == PHASE_TWO || ph_d == PHASE_THREE ||
                      ph_d == WAIT_PHASE;

  // Bus pins, registered from the next phase
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bus.cpu_ale          <= 1'b0;
      bus.cpu_rd_n         <= 1'b1;
      bus.cpu_wr_n         <= 1'b1;
      bus.int_ack_strobe_n <= 1'b1;
      bus.io_m             <= 1'b0;
      bus.cycle_type       <= CT_PASSIVE;
      bus.cpu_ad           <= 8'h00;
      bus.cpu_ad_oe_n      <= 1'b1;
      bus.a15_8            <= 8'h00;
      bus.a19_16_st        <= 4'h0;
    end
    else
    begin
      // [R05] Latch strobe, own mode only
      bus.cpu_ale <= min_mode && ph_d == PHASE_ONE;
      // [R22] Strobe window; [R24] own strobes
      bus.cpu_rd_n <= !(min_mode && strobe_win &&
                        cbi_is_read(kind_d) && kind_d != CT_INT_ACK_STROBE_N);
      bus.cpu_wr_n <= !(min_mode && strobe_win && cbi_is_write(kind_d));
      bus.int_ack_strobe_n <= !(min_mode && strobe_win &&
                                kind_d == CT_INT_ACK_STROBE_N);
      bus.io_m <= in_cycle && !kind_d[2];
      // [R06] Status code; passive at four
      if (ph_d == PH_HALT)
        bus.cycle_type <= CT_HALT;
      else if (in_cycle && ph_d != PHASE_FOUR)
        bus.cycle_type <= kind_d;
      else
        bus.cycle_type <= CT_PASSIVE;
      // [R02] Address then data
      bus.cpu_ad      <= ph_d == PHASE_ONE ? addr_d[7:0] : wdata_d;
      bus.cpu_ad_oe_n <= !(ph_d == PHASE_ONE ||
                           (in_cycle && cbi_is_write(kind_d)));
      bus.a15_8       <= in_cycle ? addr_d[15:8] : 8'h00;
      // [R07] Upper status; [R08] segment
      if (ph_d == PHASE_ONE)
        bus.a19_16_st <= addr_d[19:16];
      else if (in_cycle)
        bus.a19_16_st <= {1'b0, if_flag_out, seg_d};
      else
        bus.a19_16_st <= 4'h0;
    end
  end

  // [R18] Lock over acknowledge pair
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bus.lock_n <= 1'b1;
    else if (bus.reset)
      bus.lock_n <= 1'b1;
    else if (ph_d == PHASE_TWO && ack_d == ACK_FIRST)
      bus.lock_n <= 1'b0;
    else if (ph_d == PHASE_TWO && ack_d == ACK_SECOND)
      bus.lock_n <= 1'b1;
  end
endmodule

// File: logic/cbi_pkg.sv
package cbi_pkg;
  // Cycle-type status codes
  localparam logic [2:0] CT_INT_ACK_STROBE_N    = 3'h0;
  localparam logic [2:0] CT_IO_RD   = 3'h1;
  localparam logic [2:0] CT_IO_WR   = 3'h2;
  localparam logic [2:0] CT_HALT    = 3'h3;
  localparam logic [2:0] CT_FETCH   = 3'h4;
  localparam logic [2:0] CT_MEM_RD  = 3'h5;
  localparam logic [2:0] CT_MEM_WR  = 3'h6;
  localparam logic [2:0] CT_PASSIVE = 3'h7;
  // Segment status codes
  localparam logic [1:0] SEG_EXTRA  = 2'h0;
  localparam logic [1:0] SEG_STACK  = 2'h1;
  localparam logic [1:0] SEG_CODE   = 2'h2;
  localparam logic [1:0] SEG_DATA   = 2'h3;
  // Fixed addresses
  localparam logic [19:0] RESET_VECTOR = 20'hFFFF0;
  localparam logic [19:0] IVT_BASE     = 20'h00000;
  // Timing counts in processor clocks
  localparam int RESET_MIN_CYCLES = 4;
  localparam int RESET_SEQ_CYCLES = 10;
  localparam int NMI_MIN_CYCLES   = 2;
  localparam logic [3:0] RESET_SEQ_LAST = 4'(RESET_SEQ_CYCLES - 1);
  localparam logic [2:0] RESET_HOLD     = 3'(RESET_MIN_CYCLES + 1);
  localparam logic [1:0] NMI_HOLD       = 2'(NMI_MIN_CYCLES);
  // Acknowledge sequence position
  localparam logic [1:0] ACK_NONE   = 2'h0;
  localparam logic [1:0] ACK_FIRST  = 2'h1;
  localparam logic [1:0] ACK_SECOND = 2'h2;

  typedef enum logic [3:0] {
    PH_RST_HOLD,
    PH_RST_SEQ,
    PH_IDLE,
    PHASE_ONE,
    PHASE_TWO,
    PHASE_THREE,
    WAIT_PHASE,
    PHASE_FOUR,
    PH_HALT
  } cbi_phase_t;

  function automatic logic cbi_is_read(input logic [2:0] ct);
    return ct == CT_INT_ACK_STROBE_N || ct == CT_IO_RD || ct == CT_FETCH ||
           ct == CT_MEM_RD;
  endfunction

  function automatic logic cbi_is_write(input logic [2:0] ct);
    return ct == CT_IO_WR || ct == CT_MEM_WR;
  endfunction

  function automatic logic [19:0] cbi_io_addr(input logic [19:0] a,
                                              input logic [2:0]  ct);
    if (ct == CT_IO_RD || ct == CT_IO_WR)
      return {4'h0, a[15:0]};
    return a;
  endfunction

  function automatic logic [19:0] cbi_ivt_addr(input logic [7:0] t);
    return IVT_BASE | {10'h000, t, 2'h0};
  endfunction
endpackage

// File: logic/cbi_bus_if.sv
interface cbi_bus_if;
  logic [7:0] cpu_ad;
  logic       cpu_ad_oe_n;
  logic [7:0] far_ad;
  logic       far_ad_oe_n;
  logic [7:0] ad;
  logic [7:0] a15_8;
  logic [3:0] a19_16_st;
  logic       cpu_ale;
  logic       cpu_rd_n;
  logic       cpu_wr_n;
  logic       int_ack_strobe_n;
  logic       io_m;
  logic [2:0] cycle_type;
  logic       lock_n;
  logic       ready;
  logic       nmi;
  logic       mask_irq;
  logic       reset;
  logic       config_select;

  // Shared data lines; high level when nobody drives
  assign ad = !cpu_ad_oe_n ? cpu_ad : (!far_ad_oe_n ? far_ad : 8'hFF);

  modport cpu (
    output cpu_ad, cpu_ad_oe_n, a15_8, a19_16_st, cpu_ale, cpu_rd_n,
           cpu_wr_n, int_ack_strobe_n, io_m, cycle_type, lock_n,
    input  ad, ready, nmi, mask_irq, reset, config_select
  );

  modport sys (
    output far_ad, far_ad_oe_n, ready, nmi, mask_irq, reset,
           config_select,
    input  ad, a15_8, a19_16_st, cpu_ale, cpu_rd_n, cpu_wr_n,
           int_ack_strobe_n, io_m, cycle_type, lock_n
  );
endinterface

// File: logic/cbi_sys.sv
module cbi_sys
  import cbi_pkg::*;
#(
  parameter int MEM_AW      = 10,
  parameter int WAIT_CYCLES = 0
)
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Bus
  cbi_bus_if.sys                 bus,
  // System controls
  input  wire logic              cfg_min_in,
  input  wire logic              reset_req_in,
  input  wire logic              nmi_req_in,
  input  wire logic              irq_req_in,
  input  wire logic [7:0]        vector_in,
  // Peripheral port
  input  wire logic [7:0]        io_rd_data_in,
  output logic                   io_wr_valid_out,
  output logic [15:0]            io_addr_out,
  output logic [7:0]             io_data_out,
  output logic                   ack_done_out,
  // Memory preload
  input  wire logic              mem_ld_en_in,
  input  wire logic [MEM_AW-1:0] mem_ld_addr_in,
  input  wire logic [7:0]        mem_ld_data_in
);
  logic [7:0]  mem [2**MEM_AW];
  logic [2:0]  rst_cnt_q;
  logic [1:0]  nmi_cnt_q;
  logic [19:0] lat_q;
  logic [7:0]  wcnt_q;
  logic        st_prev_q;
  logic        ia_prev_q;
  logic        wr_prev_q;
  logic        ia_second_q;
  logic        st_act;
  logic        ale;
  logic        rd_act;
  logic        wr_act;
  logic        ia_act;
  logic        min_q;

  assign min_q  = bus.config_select;
  assign st_act = bus.cycle_type != CT_PASSIVE &&
                  bus.cycle_type != CT_HALT;
  // [R24] External controller decodes status
  assign ale    = min_q ? bus.cpu_ale : (st_act && !st_prev_q);
  assign rd_act = min_q ? !bus.cpu_rd_n :
                  (st_act && st_prev_q && cbi_is_read(bus.cycle_type) &&
                   bus.cycle_type != CT_INT_ACK_STROBE_N);
  assign wr_act = min_q ? !bus.cpu_wr_n :
                  (st_act && st_prev_q && cbi_is_write(bus.cycle_type));
  assign ia_act = min_q ? !bus.int_ack_strobe_n :
                  (st_act && st_prev_q && bus.cycle_type == CT_INT_ACK_STROBE_N);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bus.config_select <= 1'b1;
    else
      bus.config_select <= cfg_min_in;
  end

  // [R10] Reset stretched past four clocks
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_cnt_q <= RESET_HOLD;
      bus.reset <= 1'b1;
    end
    else
    begin
      if (reset_req_in)
        rst_cnt_q <= RESET_HOLD;
      else if (rst_cnt_q != 3'h0)
        rst_cnt_q <= rst_cnt_q - 3'h1;
      bus.reset <= reset_req_in || rst_cnt_q > 3'h1;
    end
  end

  // [R14] Non-maskable pulse stretched
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      nmi_cnt_q <= 2'h0;
      bus.nmi   <= 1'b0;
    end
    else
    begin
      if (nmi_req_in)
        nmi_cnt_q <= NMI_HOLD;
      else if (nmi_cnt_q != 2'h0)
        nmi_cnt_q <= nmi_cnt_q - 2'h1;
      bus.nmi <= nmi_req_in || nmi_cnt_q > 2'h1;
    end
  end

  // [R16] Request held until acknowledged
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bus.mask_irq <= 1'b0;
      ia_prev_q    <= 1'b0;
      ia_second_q  <= 1'b0;
      ack_done_out <= 1'b0;
    end
    else
    begin
      ia_prev_q    <= ia_act;
      ack_done_out <= ia_prev_q && !ia_act && ia_second_q;
      if (ia_prev_q && !ia_act)
        ia_second_q <= !ia_second_q;
      else if (bus.reset)
        ia_second_q <= 1'b0;
      if (irq_req_in)
        bus.mask_irq <= 1'b1;
      else if (ia_prev_q && !ia_act && ia_second_q)
        bus.mask_irq <= 1'b0;
    end
  end

  // [R05] Address held from the strobe's trailing edge
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lat_q     <= 20'h00000;
      st_prev_q <= 1'b0;
    end
    else
    begin
      st_prev_q <= st_act;
      if (ale)
        lat_q <= {bus.a19_16_st, bus.a15_8, bus.ad};
    end
  end

  // [R03] Ready after the set number of strobe clocks
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wcnt_q    <= 8'h00;
      bus.ready <= 1'b1;
    end
    else if (ale)
    begin
      wcnt_q    <= 8'(WAIT_CYCLES);
      bus.ready <= WAIT_CYCLES == 0;
    end
    else if ((rd_act || wr_act || ia_act) && wcnt_q != 8'h00)
    begin
      wcnt_q    <= wcnt_q - 8'h01;
      bus.ready <= wcnt_q == 8'h01;
    end
  end

  // [R19] Type byte on second acknowledge
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bus.far_ad      <= 8'h00;
      bus.far_ad_oe_n <= 1'b1;
    end
    else
    begin
      bus.far_ad_oe_n <= !(rd_act || (ia_act && ia_second_q));
      if (ia_act)
        bus.far_ad <= vector_in;
      else if (bus.io_m)
        bus.far_ad <= io_rd_data_in;
      else
        bus.far_ad <= mem[lat_q[MEM_AW-1:0]];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (mem_ld_en_in)
      mem[mem_ld_addr_in] <= mem_ld_data_in;
    else if (wr_prev_q && !wr_act && !bus.io_m)
      mem[lat_q[MEM_AW-1:0]] <= bus.ad;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_prev_q       <= 1'b0;
      io_wr_valid_out <= 1'b0;
      io_addr_out     <= 16'h0000;
      io_data_out     <= 8'h00;
    end
    else
    begin
      wr_prev_q       <= wr_act;
      io_wr_valid_out <= wr_prev_q && !wr_act && bus.io_m;
      if (wr_prev_q && !wr_act && bus.io_m)
      begin
        io_addr_out <= lat_q[15:0];
        io_data_out <= bus.ad;
      end
    end
  end
endmodule

// File: testbench/cbi_bus_assertions.sv
module cbi_bus_assertions
  import cbi_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Bus signals
  input  wire logic       cpu_ale,
  input  wire logic       cpu_rd_n,
  input  wire logic       cpu_wr_n,
  input  wire logic       int_ack_strobe_n,
  input  wire logic       io_m,
  input  wire logic [2:0] cycle_type,
  input  wire logic [3:0] a19_16_st,
  input  wire logic       lock_n,
  input  wire logic       ready,
  input  wire logic       reset,
  input  wire logic       config_select
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in || reset);

  a_ale_single: assert property (cpu_ale |=> !cpu_ale)
    else $error("ale longer than one cycle");
  a_ale_then_strobe: assert property (cpu_ale && config_select |=>
    !(cpu_rd_n && cpu_wr_n && int_ack_strobe_n))
    else $error("no strobe after ale");
  a_strobe_span: assert property ($fell(cpu_rd_n) |->
    !cpu_rd_n [*2] ##[1:8] cpu_rd_n)
    else $error("read strobe span wrong");
  a_wait_hold: assert property (!cpu_rd_n && !ready |=> !cpu_rd_n)
    else $error("strobe ended while not ready");
  a_ready_end: assert property (
    !cpu_rd_n && ready && $past(!cpu_rd_n) |=> cpu_rd_n)
    else $error("extra wait while ready");
  a_io_upper_low: assert property (cpu_ale && io_m |->
    a19_16_st == 4'h0)
    else $error("io upper address not low");
  a_status_top: assert property ($fell(cpu_ale) |-> !a19_16_st[3])
    else $error("upper status bit wrong");
  a_write_code: assert property (!cpu_wr_n |->
    (cycle_type == CT_IO_WR || cycle_type == CT_MEM_WR) &&
    io_m == (cycle_type == CT_IO_WR))
    else $error("write cycle code wrong");
  a_lock_span: assert property ($fell(lock_n) |->
    cycle_type == CT_INT_ACK_STROBE_N ##0 !lock_n [*5] ##[1:4] lock_n)
    else $error("lock span wrong");
  a_boot_fetch: assert property ($fell(reset) |->
    cycle_type == CT_PASSIVE [*5] ##1 cycle_type == CT_PASSIVE [*5]
    ##[1:4] (cycle_type == CT_FETCH && a19_16_st == 4'hF))
    else $error("boot fetch timing wrong");
endmodule

// File: testbench/cpu_bus_cycle_and_interrupt_unit_tb_top.sv
module cpu_bus_cycle_and_interrupt_unit_tb_top
  import cbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_in = 0;
  logic        rst_n_in = 0;
  int          num_errors = 0;
  int          checks_done = 0;
  int          rsp_cnt = 0;
  int          taken_cnt = 0;
  logic        req_valid_in, req_ready_out, rsp_valid_out;
  logic [2:0]  req_kind_in;
  logic [19:0] req_addr_in, int_addr_out;
  logic [1:0]  req_seg_in;
  logic [7:0]  req_wdata_in, rsp_data_out, vector_in, io_rd_data_in;
  logic        boundary_in, halt_in, if_set_in, if_clr_in, interrupt_return_in;
  logic        interrupt_return_if_in, int_taken_out, flags_push_out, if_flag_out;
  logic        halted_out, cfg_min_in, reset_req_in, nmi_req_in;
  logic        irq_req_in, io_wr_valid_out, ack_done_out, mem_ld_en_in;
  logic [15:0] io_addr_out;
  logic [7:0]  io_data_out, mem_ld_data_in;
  logic [9:0]  mem_ld_addr_in;

  cbi_bus_if bus_if ();
  cbi_cpu u_cbi_cpu (.bus(bus_if), .*);
  cbi_sys #(.WAIT_CYCLES(3)) u_cbi_sys (.bus(bus_if), .*);
  cbi_bus_assertions u_chk (
    .clk_in, .rst_n_in, .cpu_ale(bus_if.cpu_ale),
    .cpu_rd_n(bus_if.cpu_rd_n), .cpu_wr_n(bus_if.cpu_wr_n),
    .int_ack_strobe_n(bus_if.int_ack_strobe_n), .io_m(bus_if.io_m),
    .cycle_type(bus_if.cycle_type), .a19_16_st(bus_if.a19_16_st),
    .lock_n(bus_if.lock_n), .ready(bus_if.ready), .reset(bus_if.reset),
    .config_select(bus_if.config_select));

  always #50 clk_in = ~clk_in;

  always @(posedge clk_in)
  begin
    if (rsp_valid_out === 1'b1)
      rsp_cnt++;
    if (int_taken_out === 1'b1)
      taken_cnt++;
  end

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Bounded wait for a level or pulse
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      @(negedge clk_in);
      n++;
    end
    chk(20'(s), 20'h1);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_in);
    s = 1;
    @(negedge clk_in);
    s = 0;
  endtask

  task automatic send(input logic [2:0] k, input logic [19:0] a,
                      input logic [7:0] d);
    @(negedge clk_in);
    req_valid_in = 1;
    req_kind_in = k;
    req_addr_in = a;
    req_wdata_in = d;
    wait_hi(req_ready_out, 60);
    @(negedge clk_in);
    req_valid_in = 0;
  endtask

  task automatic do_read(input logic [2:0] k, input logic [19:0] a,
                         input logic [7:0] exp);
    send(k, a, 8'h00);
    wait_hi(rsp_valid_out, 30);
    chk(20'(rsp_data_out), 20'(exp));
  endtask

  task automatic t_mem;
    @(negedge clk_in);
    mem_ld_en_in = 1;
    mem_ld_addr_in = 10'h010;
    mem_ld_data_in = 8'h3C;
    @(negedge clk_in);
    mem_ld_en_in = 0;
    do_read(CT_MEM_RD, 20'h00010, 8'h3C);
    send(CT_MEM_WR, 20'h00011, 8'h5A);
    do_read(CT_MEM_RD, 20'h00011, 8'h5A);
    cfg_min_in = 0;
    tick(3);
    do_read(CT_MEM_RD, 20'h00010, 8'h3C);
    cfg_min_in = 1;
    tick(3);
  endtask

  task automatic t_io;
    io_rd_data_in = 8'hC3;
    do_read(CT_IO_RD, 20'hF1234, 8'hC3);
    send(CT_IO_WR, 20'h0ABCD, 8'h96);
    wait_hi(io_wr_valid_out, 30);
    chk(20'(io_addr_out), 20'h0ABCD);
    chk(20'(io_data_out), 20'h00096);
  endtask

  task automatic t_int;
    int n;
    vector_in = 8'h21;
    pulse(if_set_in);
    @(negedge clk_in);
    nmi_req_in = 1;
    irq_req_in = 1;
    @(negedge clk_in);
    nmi_req_in = 0;
    irq_req_in = 0;
    tick(3);
    pulse(boundary_in);
    wait_hi(int_taken_out, 20);
    chk(int_addr_out, 20'h00008);
    chk(20'(if_flag_out), 20'h0);
    chk(20'(flags_push_out), 20'h1);
    tick(1);
    n = taken_cnt;
    @(negedge clk_in);
    interrupt_return_in = 1;
    interrupt_return_if_in = 1;
    @(negedge clk_in);
    interrupt_return_in = 0;
    tick(1);
    chk(20'(if_flag_out), 20'h1);
    tick(6);
    chk(20'(taken_cnt), 20'(n));
    pulse(boundary_in);
    wait_hi(int_taken_out, 60);
    chk(int_addr_out, 20'h00084);
    chk(20'(ack_done_out), 20'h1);
    chk(20'(bus_if.mask_irq), 20'h0);
    chk(20'(if_flag_out), 20'h0);
  endtask

  task automatic t_halt;
    pulse(halt_in);
    tick(2);
    chk(20'(halted_out), 20'h1);
    chk(20'(bus_if.cycle_type), 20'(CT_HALT));
    pulse(boundary_in);
    tick(20);
    chk(20'(halted_out), 20'h1);
    pulse(nmi_req_in);
    wait_hi(int_taken_out, 20);
    tick(2);
    chk(20'(halted_out), 20'h0);
  endtask

  task automatic t_abort;
    int n;
    pulse(if_set_in);
    send(CT_MEM_RD, 20'h00010, 8'h00);
    n = rsp_cnt;
    pulse(reset_req_in);
    tick(3);
    chk(20'(if_flag_out), 20'h0);
    wait_hi(req_ready_out, 80);
    chk(20'(rsp_cnt), 20'(n + 1));
    do_read(CT_MEM_RD, 20'h00011, 8'h5A);
  endtask

  initial
  begin
    #(4000 * 100);
    num_errors++;
    stop_test();
  end

  initial
  begin
    {req_valid_in, req_kind_in, req_addr_in, req_wdata_in} = '0;
    {boundary_in, halt_in, if_set_in, if_clr_in, interrupt_return_in, interrupt_return_if_in} = '0;
    {reset_req_in, nmi_req_in, irq_req_in, vector_in} = '0;
    {io_rd_data_in, mem_ld_en_in, mem_ld_addr_in, mem_ld_data_in} = '0;
    req_seg_in = SEG_DATA;
    cfg_min_in = 1;
    tick(10);
    rst_n_in = 1;
    wait_hi(req_ready_out, 100);
    t_mem();
    t_io();
    t_int();
    t_halt();
    t_abort();
    pulse(if_set_in);
    pulse(if_clr_in);
    tick(2);
    chk(20'(if_flag_out), 20'h0);
    stop_test();
  end
endmodule
